// file: core/wdt_pkg.sv
// Package for the windowed watchdog: register map, fields, reset values.
// Assumes a 32-bit AHB-Lite slave with word-aligned registers.
package wdt_pkg;

    localparam logic [7:0]  OFF_RESTART      = 8'h00;
    localparam logic [7:0]  OFF_MODE         = 8'h04;
    localparam logic [7:0]  OFF_STATUS       = 8'h08;

    localparam logic [31:0] MODE_RESET       = 32'h3fff2fff;
    localparam logic [31:0] MODE_MASK        = 32'h3fffffff;
    localparam logic [7:0]  RESTART_KEY      = 8'ha5;
    localparam int          KEY_LSB          = 24;
    localparam int          RESTART_BIT      = 0;

    localparam int          RELOAD_LSB       = 0;
    localparam int          DELTA_LSB        = 16;
    localparam int          FIEN_BIT         = 12;
    localparam int          RSTEN_BIT        = 13;
    localparam int          PROC_SEL_BIT     = 14;
    localparam int          DISABLE_BIT      = 15;
    localparam int          DEBUG_HALT_BIT   = 28;
    localparam int          IDLE_HALT_BIT    = 29;
    localparam int          UNF_BIT          = 0;
    localparam int          ERR_BIT          = 1;

    localparam int          PRESCALE_DIV     = 128;
    localparam int          CNT_W            = 12;

    typedef struct packed {
        logic        idle_halt;
        logic        debug_halt;
        logic [11:0] restart_window_delta;
        logic        timer_disable;
        logic        processor_only_reset_select;
        logic        fault_reset_enable;
        logic        fault_interrupt_enable;
        logic [11:0] counter_reload_value;
    } mode_t;

    typedef struct packed {
        logic        window_error_flag;
        logic        underflow_flag;
    } status_t;

    function automatic mode_t unpack_mode(input logic [31:0] w);
        mode_t m;
        m.idle_halt                   = w[IDLE_HALT_BIT];
        m.debug_halt                  = w[DEBUG_HALT_BIT];
        m.restart_window_delta        = w[DELTA_LSB +: CNT_W];
        m.timer_disable               = w[DISABLE_BIT];
        m.processor_only_reset_select = w[PROC_SEL_BIT];
        m.fault_reset_enable          = w[RSTEN_BIT];
        m.fault_interrupt_enable      = w[FIEN_BIT];
        m.counter_reload_value        = w[RELOAD_LSB +: CNT_W];
        return m;
    endfunction

endpackage

// file: core/windowed_watchdog_timer.sv
// Windowed watchdog timer with AHB-Lite register slave.
// Assumes SLOW_TICK is a one-cycle pulse per slow-clock period made on
// SYS_CLK; DEBUG_STATE and IDLE_STATE come from outside and are synced.
//
// Behaviour
// - 12-bit down counter loaded from reload field
// - Decrement once per slow clock divided by 128
// - Reset: reload 0xFFF, running, reset enabled
// - Mode register writable once per processor reset
// - Mode write reloads counter and restarts counting
// - Keyed restart within window reloads counter, restarts prescaler
// - Restart write ignored unless key is 0xA5
// - Underflow sets flag, fault if reset enabled
// - Restart above delta is error and fault
// - Window check applies even when disabled
// - Delta at least reload never gives errors
// - Interrupt when flag set and enable bit
// - Fault selects all resets or processor only
// - Watchdog reset clears watchdog and flags
// - Status read clears flags, interrupt, fault
// - Halt counting in debug or idle if enabled
// - Disable bit stops the timer
// - Status: underflow bit 0, error bit 1, sticky
// - Mode: reload bits 11:0, delta 27:16
//
// Chosen here: the AHB-Lite interface to the registers.
`timescale 1ns/100ps
module windowed_watchdog_timer
    import wdt_pkg::*;
(
    input  wire logic        SYS_CLK,       // System clock, 100 MHz
    input  wire logic        RST,           // Processor reset, sync high
    input  wire logic        SLOW_TICK,     // Slow clock edge pulse
    input  wire logic        DEBUG_STATE,   // Processor in debug state
    input  wire logic        IDLE_STATE,    // System in idle mode
    input  wire logic        HSEL,          // AHB slave select
    input  wire logic [31:0] HADDR,         // AHB address
    input  wire logic [1:0]  HTRANS,        // AHB transfer type
    input  wire logic        HWRITE,        // AHB write
    input  wire logic [2:0]  HSIZE,         // AHB size
    input  wire logic [31:0] HWDATA,        // AHB write data
    input  wire logic        HREADY,        // AHB bus ready
    output logic      [31:0] HRDATA,        // AHB read data
    output logic             HREADYOUT,     // AHB slave ready
    output logic             HRESP,         // AHB response, always OKAY
    output logic             WDT_IRQ,       // Watchdog interrupt
    output logic             FAULT_ALL,     // Fault: request all resets
    output logic             FAULT_PROC     // Fault: processor reset only
);

    logic [1:0]       dbg_sync_reg;
    logic [1:0]       idle_sync_reg;
    logic             ph_wr_reg;
    logic             ph_rd_reg;
    logic [7:0]       ph_addr_reg;
    logic [31:0]      mode_word_reg;
    mode_t            mode;
    logic             mode_locked_reg;
    logic [CNT_W-1:0] count_reg;
    logic [6:0]       presc_reg;
    status_t          status_reg;
    logic             fault_reg;
    logic             addr_ok;
    logic             wr_mode;
    logic             wr_restart;
    logic             rd_status;
    logic             halted;
    logic             tick;
    logic             underflow;
    logic             win_error;
    logic             restart_ok;

    // Synchronise outside state levels
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            dbg_sync_reg  <= 2'h0;
            idle_sync_reg <= 2'h0;
        end else begin
            dbg_sync_reg  <= {dbg_sync_reg[0], DEBUG_STATE};
            idle_sync_reg <= {idle_sync_reg[0], IDLE_STATE};
        end
    end

    // AHB address phase capture
    assign addr_ok = HSEL && HREADY && HTRANS[1];
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            ph_wr_reg   <= 1'b0;
            ph_rd_reg   <= 1'b0;
            ph_addr_reg <= 8'h00;
        end else begin
            ph_wr_reg   <= addr_ok && HWRITE;
            ph_rd_reg   <= addr_ok && !HWRITE;
            ph_addr_reg <= HADDR[7:0];
        end
    end

    assign wr_mode    = ph_wr_reg && ph_addr_reg == OFF_MODE
                        && !mode_locked_reg;
    assign wr_restart = ph_wr_reg && ph_addr_reg == OFF_RESTART
                        && HWDATA[KEY_LSB +: 8] == RESTART_KEY
                        && HWDATA[RESTART_BIT];
    assign rd_status  = ph_rd_reg && ph_addr_reg == OFF_STATUS;

    assign mode = unpack_mode(mode_word_reg);

    // Mode register, write-once until processor reset
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            mode_word_reg   <= MODE_RESET;
            mode_locked_reg <= 1'b0;
        end else if (wr_mode) begin
            mode_word_reg   <= HWDATA & MODE_MASK;
            mode_locked_reg <= 1'b1;
        end
    end

    assign halted = mode.timer_disable
                    || (mode.debug_halt && dbg_sync_reg[1])
                    || (mode.idle_halt && idle_sync_reg[1]);
    assign tick   = SLOW_TICK && presc_reg == 7'(PRESCALE_DIV - 1);

    // Window check ignores the disable bit; delta >= reload never errs
    assign win_error  = wr_restart
                        && count_reg > mode.restart_window_delta;
    assign restart_ok = wr_restart && !win_error;
    assign underflow  = tick && !halted && !mode.timer_disable
                        && count_reg == '0;

    // Divide-by-128 prescaler, restarted by restart or mode write
    always_ff @(posedge SYS_CLK) begin
        if (RST || restart_ok || wr_mode) begin
            presc_reg <= 7'h00;
        end else if (SLOW_TICK && !halted) begin
            presc_reg <= presc_reg + 7'h01;
        end
    end

    // Down counter
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            count_reg <= MODE_RESET[RELOAD_LSB +: CNT_W];
        end else if (wr_mode) begin
            count_reg <= HWDATA[RELOAD_LSB +: CNT_W];
        end else if (restart_ok) begin
            count_reg <= mode.counter_reload_value;
        end else if (underflow) begin
            count_reg <= mode.counter_reload_value;
        end else if (tick && !halted) begin
            count_reg <= count_reg - 12'h001;
        end
    end

    // Sticky status and fault; a new event wins over a status read
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            status_reg <= '0;
            fault_reg  <= 1'b0;
        end else begin
            status_reg.underflow_flag <= underflow
                || (status_reg.underflow_flag && !rd_status);
            status_reg.window_error_flag <= win_error
                || (status_reg.window_error_flag && !rd_status);
            fault_reg <= (underflow && mode.fault_reset_enable)
                || win_error
                || (fault_reg && !rd_status);
        end
    end

    // Registered outputs
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            HRDATA     <= 32'h00000000;
            WDT_IRQ    <= 1'b0;
            FAULT_ALL  <= 1'b0;
            FAULT_PROC <= 1'b0;
        end else begin
            HRDATA <= 32'h00000000;
            if (addr_ok && !HWRITE && HADDR[7:0] == OFF_MODE) begin
                HRDATA <= mode_word_reg;
            end else if (addr_ok && !HWRITE && HADDR[7:0] == OFF_STATUS) begin
                HRDATA <= {30'h0, status_reg};
            end
            WDT_IRQ <= mode.fault_interrupt_enable
                && (status_reg.underflow_flag
                    || status_reg.window_error_flag);
            FAULT_ALL  <= fault_reg && mode.fault_reset_enable
                && !mode.processor_only_reset_select;
            FAULT_PROC <= fault_reg && mode.fault_reset_enable
                && mode.processor_only_reset_select;
        end
    end

    assign HREADYOUT = 1'b1;
    assign HRESP     = 1'b0;

endmodule // windowed_watchdog_timer

// file: tb/wdt_slow_tick_model.sv
// Slow clock source: one-cycle tick every DIV system cycles.
// Assumes the watchdog samples SLOW_TICK on SYS_CLK.
`timescale 1ns/100ps
module wdt_slow_tick_model #(
    parameter int DIV = 2              // System cycles per slow period
) (
    input  wire logic SYS_CLK,         // System clock
    input  wire logic RST,             // Reset
    output logic      SLOW_TICK        // Slow clock edge pulse
);
    int cnt;
    always_ff @(posedge SYS_CLK) begin
        cnt       <= (RST || cnt == DIV - 1) ? 0 : cnt + 1;
        SLOW_TICK <= !RST && cnt == DIV - 1;
    end
endmodule // wdt_slow_tick_model

// file: tb/windowed_watchdog_timer_sva.sv
// Port checker for the watchdog; bound to the design below.
// Assumes one master and zero wait states.
`timescale 1ns/100ps
module windowed_watchdog_timer_sva
    import wdt_pkg::*;
(
    input wire logic        SYS_CLK,    // Clock
    input wire logic        RST,        // Reset
    input wire logic        HSEL,       // Select
    input wire logic [31:0] HADDR,      // Address
    input wire logic [1:0]  HTRANS,     // Transfer type
    input wire logic        HWRITE,     // Write
    input wire logic        HREADY,     // Bus ready
    input wire logic [31:0] HRDATA,     // Read data
    input wire logic        HREADYOUT,  // Slave ready
    input wire logic        HRESP,      // Response
    input wire logic        WDT_IRQ,    // Interrupt
    input wire logic        FAULT_ALL,  // All-reset fault
    input wire logic        FAULT_PROC  // Processor fault
);
    logic       rd_phase;
    logic       st_rd;
    logic [5:0] st_hist;
    assign st_rd = HSEL && HREADY && HTRANS[1] && !HWRITE
                   && HADDR[7:0] == OFF_STATUS;
    always_ff @(posedge SYS_CLK) begin
        rd_phase <= !RST && HSEL && HREADY && HTRANS[1] && !HWRITE;
        st_hist  <= RST ? 6'h00 : {st_hist[4:0], st_rd};
    end
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (RST);
    property p_resp; HREADYOUT && !HRESP; endproperty
    a_resp: assert property (p_resp) else $error("bus answer not okay");
    property p_excl; !(FAULT_ALL && FAULT_PROC); endproperty
    a_excl: assert property (p_excl) else $error("both faults");
    property p_rst; $fell(RST) |-> !WDT_IRQ && !FAULT_ALL && !FAULT_PROC;
    endproperty
    a_rst: assert property (p_rst) else $error("reset kept flag");
    property p_rd_idle; !rd_phase |-> HRDATA == 32'h0; endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("stray read data");
    property p_st_bits; st_hist[0] |-> HRDATA[31:2] == 30'h0; endproperty
    a_st_bits: assert property (p_st_bits) else $error("status bits");
    property p_irq_hold; $fell(WDT_IRQ) |-> |st_hist; endproperty
    a_irq_hold: assert property (p_irq_hold) else $error("irq lost");
    property p_all_hold; $fell(FAULT_ALL) |-> |st_hist; endproperty
    a_all_hold: assert property (p_all_hold) else $error("fault lost");
    property p_proc_hold; $fell(FAULT_PROC) |-> |st_hist; endproperty
    a_proc_hold: assert property (p_proc_hold) else $error("fault lost");
    property p_rd_clr;
        st_rd |-> ##4 !WDT_IRQ && !FAULT_ALL && !FAULT_PROC;
    endproperty
    a_rd_clr: assert property (p_rd_clr) else $error("read kept flag");
    c_all: cover property ($rose(FAULT_ALL));
    c_proc: cover property ($rose(FAULT_PROC));
    c_clear: cover property (st_rd ##4 !WDT_IRQ);
endmodule // windowed_watchdog_timer_sva
bind windowed_watchdog_timer windowed_watchdog_timer_sva
    windowed_watchdog_timer_sva_i (.SYS_CLK, .RST, .HSEL, .HADDR, .HTRANS,
    .HWRITE, .HREADY, .HRDATA, .HREADYOUT, .HRESP, .WDT_IRQ, .FAULT_ALL,
    .FAULT_PROC);

// file: tb/windowed_watchdog_timer_tb.sv
// Self-checking bench for the watchdog over AHB-Lite.
// Assumes a tick model as slow clock, idle held low, debug raised in t_halt.
`timescale 1ns/100ps
module windowed_watchdog_timer_tb;
    import wdt_pkg::*;
    logic        SYS_CLK, RST, SLOW_TICK, HSEL, HWRITE, HREADYOUT, HRESP;
    logic        WDT_IRQ, FAULT_ALL, FAULT_PROC, dbg;
    logic [31:0] HADDR, HWDATA, HRDATA, rd;
    logic [1:0]  HTRANS;
    logic [2:0]  HSIZE;
    int          fail_count = 0;
    int          checked = 0;
    wdt_slow_tick_model wdt_slow_tick_model_i (.SYS_CLK, .RST, .SLOW_TICK);
    windowed_watchdog_timer windowed_watchdog_timer_i (.SYS_CLK, .RST,
        .SLOW_TICK, .DEBUG_STATE(dbg), .IDLE_STATE(1'b0), .HSEL, .HADDR,
        .HTRANS, .HWRITE, .HSIZE, .HWDATA, .HREADY(HREADYOUT), .HRDATA,
        .HREADYOUT, .HRESP, .WDT_IRQ, .FAULT_ALL, .FAULT_PROC);
    task test_done;
        $display("checks %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected at %0t: %h expected %h", $time, seen, exp);
        end
    endtask
    task rdy(input logic irq, input int lim);
        int n;
        n = 0;
        @(posedge SYS_CLK);
        while ((irq ? WDT_IRQ : HREADYOUT) !== 1'b1) begin
            n++;
            if (n > lim) begin
                fail_count++;
                test_done;
            end
            @(posedge SYS_CLK);
        end
    endtask
    task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        HSEL   <= 1'b1;
        HADDR  <= {24'h0, a};
        HTRANS <= 2'b10;
        HWRITE <= w;
        rdy(1'b0, 50);
        HSEL   <= 1'b0;
        HTRANS <= 2'b00;
        HWDATA <= d;
        rdy(1'b0, 50);
        rd = HRDATA;
    endtask
    task reset_dut;
        RST <= 1'b1;
        repeat (5) @(posedge SYS_CLK);
        RST <= 1'b0;
        @(posedge SYS_CLK);
    endtask
    task t_defaults;
        xfer(1'b0, OFF_MODE, 32'h0);
        chk(rd, MODE_RESET);
        xfer(1'b1, OFF_RESTART, {RESTART_KEY, 24'h000001});
        xfer(1'b0, OFF_STATUS, 32'h0);
        chk(rd, 32'h0);
        xfer(1'b0, 8'h0c, 32'h0);
        chk(rd, 32'h0);
        $display("defaults done");
    endtask
    task t_window;
        xfer(1'b1, OFF_MODE, 32'h0010_3100);
        xfer(1'b1, OFF_MODE, MODE_RESET);
        xfer(1'b0, OFF_MODE, 32'h0);
        chk(rd, 32'h0010_3100);
        xfer(1'b1, OFF_RESTART, {8'h5a, 24'h000001});
        repeat (4) @(posedge SYS_CLK);
        chk(WDT_IRQ, 1'b0);
        xfer(1'b1, OFF_RESTART, {RESTART_KEY, 24'h000001});
        rdy(1'b1, 10);
        chk({FAULT_ALL, FAULT_PROC}, 2'b10);
        xfer(1'b0, OFF_STATUS, 32'h0);
        chk(rd, 32'h2);
        repeat (4) @(posedge SYS_CLK);
        chk({WDT_IRQ, FAULT_ALL}, 2'b00);
        $display("window done");
    endtask
    task t_underflow;
        reset_dut;
        xfer(1'b1, OFF_MODE, 32'h0fff_7002);
        repeat (600) @(posedge SYS_CLK);
        chk(WDT_IRQ, 1'b0);
        rdy(1'b1, 400);
        chk({FAULT_ALL, FAULT_PROC}, 2'b01);
        reset_dut;
        chk(FAULT_PROC, 1'b0);
        xfer(1'b0, OFF_STATUS, 32'h0);
        chk(rd, 32'h0);
        $display("underflow done");
    endtask
    task t_disabled;
        reset_dut;
        xfer(1'b1, OFF_MODE, 32'h0000_b001);
        repeat (800) @(posedge SYS_CLK);
        chk(WDT_IRQ, 1'b0);
        xfer(1'b1, OFF_RESTART, {RESTART_KEY, 24'h000001});
        rdy(1'b1, 10);
        chk(FAULT_ALL, 1'b1);
        $display("disabled done");
    endtask
    task t_halt;
        reset_dut;
        xfer(1'b1, OFF_MODE, 32'h1fff_1001);
        dbg <= 1'b1;
        repeat (1000) @(posedge SYS_CLK);
        chk(WDT_IRQ, 1'b0);
        dbg <= 1'b0;
        rdy(1'b1, 700);
        chk(FAULT_ALL, 1'b0);
        xfer(1'b0, OFF_STATUS, 32'h0);
        chk(rd, 32'h1);
        $display("halt done");
    endtask
    initial begin
        SYS_CLK = 1'b0;
        forever #5 SYS_CLK = ~SYS_CLK;
    end
    initial begin
        {RST, HSEL, HWRITE, HTRANS, HSIZE} = {3'b100, 2'b00, 3'b010};
        {HADDR, HWDATA} = 64'h0;
        dbg = 1'b0;
        reset_dut;
        t_defaults;
        t_window;
        t_underflow;
        t_disabled;
        t_halt;
        test_done;
    end
endmodule // windowed_watchdog_timer_tb
